/* gpib_pkg.sv */
// Shared types and constants for the instrument-bus talker/listener block.
package gpib_pkg;

   // ----------------------------------------------------------------
   // Command bytes and address fields
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_UNLISTEN  = 8'h3F;
   localparam logic [7:0] CMD_UNTALK    = 8'h5F;
   localparam logic [1:0] GRP_LISTEN    = 2'h1;
   localparam logic [1:0] GRP_TALK      = 2'h2;
   localparam int         GRP_MSB       = 6;
   localparam int         GRP_LSB       = 5;
   localparam int         ADDR_MSB      = 4;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ       = 25;
   localparam int SETTLE_NS     = 500;
   localparam int SETTLE_CYC    = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int SYNC_STAGES   = 3;

   // ----------------------------------------------------------------
   // Bus pin bundles (open-drain lines: oe low means pull low)
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] dio;
      logic       dav;
      logic       nrfd;
      logic       ndac;
      logic       atn;
      logic       ifc;
      logic       eoi;
   } bus_in_s;

   typedef struct packed {
      logic [7:0] dio_oe_n;
      logic       dav_oe_n;
      logic       nrfd_oe_n;
      logic       ndac_oe_n;
      logic       eoi_oe_n;
      logic       srq_oe_n;
   } bus_out_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LSN_READY,
      ST_LSN_ACCEPT,
      ST_TLK_DRIVE,
      ST_TLK_SETTLE,
      ST_TLK_VALID,
      ST_TLK_DONE
   } hs_state_e;

endpackage

/* gpib_sync.sv */
// Three-stage synchroniser with agreement filter for asynchronous bus lines.
`timescale 1ns/1ps
module gpib_sync #(
   parameter int WIDTH = 13
) (
   input  wire logic             mclk,
   input  wire logic             arst_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } sync_s;

   sync_s st_reg;
   sync_s st_next;

   // A line only changes once the second and third stages agree, filtering one-stage glitches.
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.q[i] = st_reg.s3[i];
         end
      end
   end

   // Idle bus lines float high, so the reset value is all ones.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sync_out = st_reg.q;

endmodule

/* gpib_three_wire_handshake.sv */
// Talker/listener interface logic: three-wire handshake and bus addressing.
`timescale 1ns/1ps
module gpib_three_wire_handshake #(
   parameter int SETTLE_CYCLES = gpib_pkg::SETTLE_CYC
) (
   input  wire logic              mclk,
   input  wire logic              arst_n,
   input  wire gpib_pkg::bus_in_s bus_in,
   output gpib_pkg::bus_out_s     bus_out,
   output logic [7:0]             dio_out,
   input  wire logic [4:0]        my_addr,
   input  wire logic              talk_only,
   input  wire logic              srq_req,
   input  wire logic [7:0]        tx_data,
   input  wire logic              tx_eoi,
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   output logic [7:0]             rx_data,
   output logic                   rx_eoi,
   output logic                   rx_valid,
   input  wire logic              rx_ready,
   output logic                   is_listener,
   output logic                   is_talker
);

   // ----------------------------------------------------------------
   // Synchronised bus inputs
   // ----------------------------------------------------------------
   gpib_pkg::bus_in_s bus_s;

   gpib_sync #(
      .WIDTH   ($bits(gpib_pkg::bus_in_s))
   ) u_sync (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .async_in (bus_in),
      .sync_out (bus_s)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      gpib_pkg::hs_state_e state;
      logic [7:0]          settle_cnt;
      logic                lad;
      logic                tad;
      logic [7:0]          dio_oe_n;
      logic                dav_oe_n;
      logic                nrfd_oe_n;
      logic                ndac_oe_n;
      logic                eoi_oe_n;
      logic                srq_oe_n;
      logic                tx_ready;
      logic [7:0]          rx_data;
      logic                rx_eoi;
      logic                rx_valid;
   } hs_s;

   hs_s st_reg;
   hs_s st_next;

   localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYCLES - 1);

   // Address decode of a command byte; used for listen and talk groups.
   function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] grp, input logic [4:0] a);
      addr_hit = (b[gpib_pkg::GRP_MSB:gpib_pkg::GRP_LSB] == grp) && (b[gpib_pkg::ADDR_MSB:0] == a);
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.srq_oe_n = ~srq_req;
      st_next.tx_ready = 1'b0;
      if (st_reg.rx_valid && rx_ready) begin
         st_next.rx_valid = 1'b0;
      end
      // Talk-only instruments act as talker without being addressed.
      if (talk_only) begin
         st_next.tad = 1'b1;
         st_next.lad = 1'b0;
      end

      unique case (st_reg.state)
         gpib_pkg::ST_IDLE: begin
            // Both open-drain lines are held low while idle and listening is possible.
            st_next.dav_oe_n  = 1'b1;
            st_next.dio_oe_n  = '1;
            st_next.eoi_oe_n  = 1'b1;
            if (!bus_s.atn || (st_reg.lad && !bus_s.atn)) begin
               st_next.ndac_oe_n = ~st_reg.lad;
               st_next.nrfd_oe_n = ~st_reg.lad;
            end else begin
               st_next.ndac_oe_n = 1'b0;
               st_next.nrfd_oe_n = 1'b0;
            end
            if (!bus_s.atn && st_reg.tad && tx_valid && bus_s.dav) begin
               // Data lines are negative logic: a one bit pulls its line low.
               st_next.dio_oe_n  = ~tx_data;
               st_next.dav_oe_n  = 1'b1;
               st_next.eoi_oe_n  = ~tx_eoi;
               st_next.tx_ready  = 1'b1;
               st_next.state     = gpib_pkg::ST_TLK_DRIVE;
            end else if (!bus_s.atn && !st_reg.lad) begin
               st_next.state = gpib_pkg::ST_IDLE;
            end else if (!st_reg.rx_valid && bus_s.dav) begin
               // Ready only when nothing is pending; NDAC stays low meanwhile.
               st_next.nrfd_oe_n = 1'b1;
               st_next.ndac_oe_n = 1'b0;
               st_next.state     = gpib_pkg::ST_LSN_READY;
            end
         end
         gpib_pkg::ST_LSN_READY: begin
            // An unaddressed instrument leaves once attention drops, so it never takes a data byte.
            if (!bus_s.atn && !st_reg.lad) begin
               st_next.state = gpib_pkg::ST_IDLE;
            end else if (!bus_s.dav) begin
               // Byte is captured and ready is withdrawn in the same cycle that accepted is released.
               st_next.nrfd_oe_n = 1'b0;
               st_next.ndac_oe_n = 1'b1;
               if (!bus_s.atn) begin
                  st_next.rx_data  = ~bus_s.dio;
                  st_next.rx_eoi   = ~bus_s.eoi;
                  st_next.rx_valid = 1'b1;
               end else begin
                  if (addr_hit(~bus_s.dio, gpib_pkg::GRP_LISTEN, my_addr) && !talk_only) begin
                     st_next.lad = 1'b1;
                  end
                  if (~bus_s.dio == gpib_pkg::CMD_UNLISTEN) begin
                     st_next.lad = 1'b0;
                  end
                  if (addr_hit(~bus_s.dio, gpib_pkg::GRP_TALK, my_addr)) begin
                     st_next.tad = 1'b1;
                  end else if ((~bus_s.dio) == gpib_pkg::CMD_UNTALK
                               || (~bus_s.dio[gpib_pkg::GRP_MSB:gpib_pkg::GRP_LSB]) == gpib_pkg::GRP_TALK) begin
                     st_next.tad = talk_only;
                  end
               end
               st_next.state = gpib_pkg::ST_LSN_ACCEPT;
            end
         end
         gpib_pkg::ST_LSN_ACCEPT: begin
            if (bus_s.dav) begin
               st_next.ndac_oe_n = 1'b0;
               st_next.state     = gpib_pkg::ST_IDLE;
            end
         end
         gpib_pkg::ST_TLK_DRIVE: begin
            // Wait for every listener to be ready (wired AND high).
            if (bus_s.nrfd && !bus_s.ndac) begin
               st_next.settle_cnt = SETTLE_LOAD;
               st_next.state      = gpib_pkg::ST_TLK_SETTLE;
            end
         end
         gpib_pkg::ST_TLK_SETTLE: begin
            if (st_reg.settle_cnt == 8'h00) begin
               st_next.dav_oe_n = 1'b0;
               st_next.state    = gpib_pkg::ST_TLK_VALID;
            end else begin
               st_next.settle_cnt = st_reg.settle_cnt - 8'h01;
            end
         end
         gpib_pkg::ST_TLK_VALID: begin
            if (bus_s.ndac) begin
               st_next.dav_oe_n = 1'b1;
               st_next.state    = gpib_pkg::ST_TLK_DONE;
            end
         end
         gpib_pkg::ST_TLK_DONE: begin
            if (!bus_s.ndac) begin
               st_next.dio_oe_n  = '1;
               st_next.eoi_oe_n  = 1'b1;
               st_next.state     = gpib_pkg::ST_IDLE;
            end
         end
      endcase

      // Attention aborts a talk transfer; the controller owns the bus.
      if (bus_s.atn && st_reg.state inside {gpib_pkg::ST_TLK_DRIVE, gpib_pkg::ST_TLK_SETTLE,
                                            gpib_pkg::ST_TLK_VALID, gpib_pkg::ST_TLK_DONE}) begin
         st_next.dav_oe_n  = 1'b1;
         st_next.dio_oe_n  = '1;
         st_next.eoi_oe_n  = 1'b1;
         st_next.state     = gpib_pkg::ST_IDLE;
      end
      if (bus_s.ifc) begin
         st_next.lad       = 1'b0;
         st_next.tad       = talk_only;
         st_next.dav_oe_n  = 1'b1;
         st_next.nrfd_oe_n = 1'b1;
         st_next.ndac_oe_n = 1'b1;
         st_next.eoi_oe_n  = 1'b1;
         st_next.dio_oe_n  = '1;
         st_next.state     = gpib_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg           <= '0;
         st_reg.state     <= gpib_pkg::ST_IDLE;
         st_reg.dav_oe_n  <= 1'b1;
         st_reg.nrfd_oe_n <= 1'b1;
         st_reg.ndac_oe_n <= 1'b1;
         st_reg.eoi_oe_n  <= 1'b1;
         st_reg.srq_oe_n  <= 1'b1;
         st_reg.dio_oe_n  <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus_out.dio_oe_n  = st_reg.dio_oe_n;
   assign bus_out.dav_oe_n  = st_reg.dav_oe_n;
   assign bus_out.nrfd_oe_n = st_reg.nrfd_oe_n;
   assign bus_out.ndac_oe_n = st_reg.ndac_oe_n;
   assign bus_out.eoi_oe_n  = st_reg.eoi_oe_n;
   assign bus_out.srq_oe_n  = st_reg.srq_oe_n;
   assign dio_out           = 8'h00;
   assign tx_ready          = st_reg.tx_ready;
   assign rx_data           = st_reg.rx_data;
   assign rx_eoi            = st_reg.rx_eoi;
   assign rx_valid          = st_reg.rx_valid;
   assign is_listener       = st_reg.lad;
   assign is_talker         = st_reg.tad;

endmodule

/* gpib_three_wire_handshake_props.sv */
// Concurrent checks on the ports of the talker/listener block.
`timescale 1ns/1ps
module gpib_three_wire_handshake_props #(
   parameter int SETTLE_CYCLES = gpib_pkg::SETTLE_CYC
) (
   input wire logic               mclk,
   input wire logic               arst_n,
   input wire gpib_pkg::bus_in_s  bus_in,
   input wire gpib_pkg::bus_out_s bus_out,
   input wire logic [7:0]         dio_out,
   input wire logic [4:0]         my_addr,
   input wire logic               talk_only,
   input wire logic               srq_req,
   input wire logic [7:0]         tx_data,
   input wire logic               tx_eoi,
   input wire logic               tx_valid,
   input wire logic               tx_ready,
   input wire logic [7:0]         rx_data,
   input wire logic               rx_eoi,
   input wire logic               rx_valid,
   input wire logic               rx_ready,
   input wire logic               is_listener,
   input wire logic               is_talker
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   property p_srq; $rose(srq_req) |-> ##[1:5] !bus_out.srq_oe_n; endproperty
   a_srq: assert property (p_srq) else $error("service request line not pulled");
   property p_ifc; $rose(bus_in.ifc) ##1 bus_in.ifc [*7] |-> !is_listener && !is_talker && bus_out.dav_oe_n && bus_out.ndac_oe_n; endproperty
   a_ifc: assert property (p_ifc) else $error("interface clear did not reset roles");
   property p_tonly; $rose(is_listener) |-> !talk_only; endproperty
   a_tonly: assert property (p_tonly) else $error("listener role taken in talk only mode");
   property p_take; tx_ready |-> is_talker && bus_out.dav_oe_n; endproperty
   a_take: assert property (p_take) else $error("byte taken outside talker idle");
   property p_dav_on; $fell(bus_out.dav_oe_n) |-> bus_in.nrfd && !bus_in.ndac && $past(bus_in.nrfd, SETTLE_CYCLES); endproperty
   a_dav_on: assert property (p_dav_on) else $error("data valid without settled readiness");
   property p_dav_hold; !bus_out.dav_oe_n && !bus_in.ndac && !bus_in.ifc |=> !bus_out.dav_oe_n; endproperty
   a_dav_hold: assert property (p_dav_hold) else $error("data valid dropped before acceptance");
   property p_dav_off; !bus_out.dav_oe_n && bus_in.ndac |-> ##[1:6] bus_out.dav_oe_n; endproperty
   a_dav_off: assert property (p_dav_off) else $error("data valid not removed after acceptance");
   property p_dio_hold; !bus_out.dav_oe_n |=> $stable(bus_out.dio_oe_n) || bus_out.dav_oe_n; endproperty
   a_dio_hold: assert property (p_dio_hold) else $error("data lines moved while valid");
   property p_rx_stall; rx_valid && $past(rx_valid) && !$past(rx_ready) |-> !bus_out.nrfd_oe_n; endproperty
   a_rx_stall: assert property (p_rx_stall) else $error("ready given with a byte pending");
   property p_ndac_rel; $rose(bus_out.ndac_oe_n) && is_listener |-> !bus_out.nrfd_oe_n && !bus_in.dav; endproperty
   a_ndac_rel: assert property (p_ndac_rel) else $error("accepted released out of order");
   property p_nrfd_rel; $rose(bus_out.nrfd_oe_n) && is_listener |-> !bus_out.ndac_oe_n; endproperty
   a_nrfd_rel: assert property (p_nrfd_rel) else $error("ready released without accepted held");
   c_talk: cover property ($fell(bus_out.dav_oe_n));
   c_rx: cover property ($rose(rx_valid));
   c_lsn: cover property ($rose(is_listener));
   c_tlk: cover property ($rose(is_talker));
endmodule

bind gpib_three_wire_handshake gpib_three_wire_handshake_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
   .mclk(mclk), .arst_n(arst_n), .bus_in(bus_in), .bus_out(bus_out), .dio_out(dio_out), .my_addr(my_addr),
   .talk_only(talk_only), .srq_req(srq_req), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .is_listener(is_listener), .is_talker(is_talker));

/* gpib_far_end.sv */
// Bus partner model: controller and other instruments on the open-drain bus.
`timescale 1ns/1ps
module gpib_far_end (
   input  wire logic               mclk,
   input  wire gpib_pkg::bus_out_s bus_out,
   output gpib_pkg::bus_in_s       bus_in
);
   logic [7:0] p_dio = 8'h00;
   logic       p_dav = 1'b0, p_nrfd = 1'b0, p_ndac = 1'b0, p_eoi = 1'b0, p_atn = 1'b0, p_ifc = 1'b0;
   logic       ok = 1'b1;
   // A handshake or data line reads high only when no party pulls it; released lines float to the pull-up. ATN and IFC follow the controller directly.
   assign bus_in.dio  = ~p_dio & bus_out.dio_oe_n;
   assign bus_in.dav  = ~p_dav & bus_out.dav_oe_n;
   assign bus_in.nrfd = ~p_nrfd & bus_out.nrfd_oe_n;
   assign bus_in.ndac = ~p_ndac & bus_out.ndac_oe_n;
   assign bus_in.eoi  = ~p_eoi & bus_out.eoi_oe_n;
   assign bus_in.atn  = p_atn;
   assign bus_in.ifc  = p_ifc;
   function automatic logic lvl(input int sel);
      return (sel == 0) ? bus_in.nrfd : (sel == 1) ? bus_in.ndac : bus_in.dav;
   endfunction
   task automatic wfor(input int sel, input logic v);
      int n;
      n = 0;
      while (lvl(sel) !== v && n < 400) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 400) ok = 1'b0;
   endtask
   // Source side: byte first with valid released, valid only after ready and a settling gap.
   task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
      @(posedge mclk);
      p_nrfd <= 1'b0;
      p_ndac <= 1'b0;
      p_atn <= atn;
      p_dio <= b;
      p_eoi <= eoi;
      @(posedge mclk);
      wfor(1, 1'b0);
      wfor(0, 1'b1);
      repeat (3) @(posedge mclk);
      p_dav <= 1'b1;
      wfor(1, 1'b1);
      @(posedge mclk);
      p_dav <= 1'b0;
      wfor(1, 1'b0);
      @(posedge mclk);
      p_dio <= 8'h00;
      p_eoi <= 1'b0;
   endtask
   // Acceptor side; a slow setting stretches both the ready and the accepted phases.
   task automatic recv(input int slow, output logic [7:0] b, output logic e);
      @(posedge mclk);
      p_atn <= 1'b0;
      p_ndac <= 1'b1;
      p_nrfd <= 1'b1;
      repeat (slow) @(posedge mclk);
      p_nrfd <= 1'b0;
      wfor(2, 1'b0);
      b = ~bus_in.dio;
      e = ~bus_in.eoi;
      @(posedge mclk);
      p_nrfd <= 1'b1;
      repeat (slow) @(posedge mclk);
      p_ndac <= 1'b0;
      wfor(2, 1'b1);
      @(posedge mclk);
      p_ndac <= 1'b1;
   endtask
endmodule

/* test_gpib_three_wire_handshake.sv */
// Self-checking bench for the talker/listener block against the bus partner model.
`timescale 1ns/1ps
module test_gpib_three_wire_handshake;
   localparam int      SETTLE = 2;
   logic               mclk = 1'b0, arst_n = 1'b0, talk_only = 1'b0, srq_req = 1'b0;
   logic               tx_eoi = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, ge;
   logic [4:0]         my_addr = 5'h00;
   logic [7:0]         tx_data = 8'h00, rx_data, got, dio_lvl, q[4];
   logic               tx_ready, rx_eoi, rx_valid, is_listener, is_talker;
   gpib_pkg::bus_in_s  bus_in;
   gpib_pkg::bus_out_s bus_out;
   int                 errors = 0, compares = 0, seed;

   always #20 mclk = ~mclk;

   gpib_three_wire_handshake #(.SETTLE_CYCLES(SETTLE)) dut (
      .mclk(mclk), .arst_n(arst_n), .bus_in(bus_in), .bus_out(bus_out), .dio_out(dio_lvl), .my_addr(my_addr),
      .talk_only(talk_only), .srq_req(srq_req), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_eoi(rx_eoi), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .is_listener(is_listener), .is_talker(is_talker));
   gpib_far_end far (.mclk(mclk), .bus_out(bus_out), .bus_in(bus_in));

   function automatic logic [7:0] addr_byte(input logic [1:0] grp, input logic [4:0] a);
      return {1'b0, grp, a};
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wait_flag(input int sel);
      int n;
      n = 0;
      while ((sel ? tx_ready : rx_valid) !== 1'b1 && n < 500) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 500) begin
         errors++;
         $display("wrong value at %0t: flag wait ran out", $time);
         wrap_up;
      end
   endtask
   // Roles settle a few cycles after the handshake because of input synchronisation.
   task automatic cmd(input logic [7:0] b);
      far.send(b, 1'b1, 1'b0);
      repeat (6) @(posedge mclk);
   endtask

   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up;
   end

   initial begin
      seed = $urandom(32'h94da924c);
      my_addr <= 5'($urandom_range(30));
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      cmd(addr_byte(gpib_pkg::GRP_LISTEN, my_addr));
      chk(is_listener, 1'b1);
      chk(rx_valid, 1'b0);
      foreach (q[i]) q[i] = 8'($urandom);
      far.send(q[0], 1'b0, 1'b0);
      for (int i = 1; i <= 4; i++) begin
         fork
            if (i < 4) far.send(q[i], 1'b0, i == 3);
            begin
               wait_flag(0);
               chk(rx_data, q[i-1]);
               chk(rx_eoi, i == 4);
               repeat (12) @(posedge mclk);
               chk(bus_in.dav, 1'b1);
               rx_ready <= 1'b1;
               @(posedge mclk);
               rx_ready <= 1'b0;
            end
         join
      end
      cmd(gpib_pkg::CMD_UNLISTEN);
      chk(is_listener, 1'b0);
      cmd(addr_byte(gpib_pkg::GRP_TALK, my_addr));
      chk(is_talker, 1'b1);
      for (int i = 0; i < 4; i++) begin
         tx_data <= 8'($urandom);
         tx_eoi <= (i == 3);
         tx_valid <= 1'b1;
         fork
            far.recv(i[0] ? 9 : 1, got, ge);
            begin
               wait_flag(1);
               tx_valid <= 1'b0;
            end
         join
         chk(got, tx_data);
         chk(ge, tx_eoi);
      end
      cmd(addr_byte(gpib_pkg::GRP_TALK, my_addr + 5'h01));
      chk(is_talker, 1'b0);
      cmd(addr_byte(gpib_pkg::GRP_LISTEN, my_addr));
      far.p_atn <= 1'b0;
      far.p_ifc <= 1'b1;
      repeat (10) @(posedge mclk);
      chk(is_listener, 1'b0);
      far.p_ifc <= 1'b0;
      talk_only <= 1'b1;
      srq_req <= 1'b1;
      cmd(addr_byte(gpib_pkg::GRP_LISTEN, my_addr));
      chk(is_listener, 1'b0);
      chk(bus_out.srq_oe_n, 1'b0);
      chk(dio_lvl, 8'h00);
      chk(far.ok, 1'b1);
      wrap_up;
   end
endmodule
